/* core/iser_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - status shows level of latest presented interrupt
// - status shows source index being presented
// - unimplemented status bits always read zero
// - reload value loads proximity timer on trigger
// - flag bit one means request occurred
// - enable bit one enables its source
// - control bit selects multi or single handler
// - threshold starts timer at/below level; zero disables
// - per-source priority (zero disables), subpriority 0-3
// - clear, set, invert aliases at +4,+8,+C, except status and event status
module iser_top
  import iser_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ISER_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  input wire logic [ISER_SRC_N-1:0] src_req,
  output iser_cpu_req_t cpu_req_ff,
  output logic [ISER_IDX_W-1:0] cpu_handler_ff,
  output logic prox_expired_ff,
  output logic irq_ff
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // software-visible and sticky state, with next values
  logic [31:0] control_ff, nxt_control;
  logic [31:0] reload_ff, nxt_reload;
  logic [31:0] flag_ff, nxt_flag;
  logic [31:0] enable_ff, nxt_enable;
  logic [ISER_PRIO_WORDS-1:0][31:0] prio_ff, nxt_prio;
  logic [31:0] evt_stat_ff, nxt_evt_stat;
  logic [31:0] evt_mask_ff, nxt_evt_mask;
  logic [31:0] prox_cnt_ff, nxt_prox_cnt;
  logic [ISER_LVL_W-1:0] last_level_ff, nxt_last_level;
  logic [31:0] nxt_prdata;
  logic nxt_pready, nxt_pslverr;
  iser_cpu_req_t nxt_cpu_req;
  logic [ISER_IDX_W-1:0] nxt_cpu_handler;
  logic nxt_prox_expired, nxt_irq;

  // decode, selection and event helpers
  logic access, wr_en, rd_en, mapped;
  logic [1:0] alias_sel;
  logic [7:0] base;
  logic [ISER_SRC_N-1:0] eligible;
  logic [ISER_SRC_N-1:0][ISER_KEY_W-1:0] key;
  logic found;
  logic [ISER_IDX_W-1:0] best_idx;
  logic [ISER_KEY_W-1:0] best_key;
  logic multi_handler_select;
  logic [ISER_LVL_W-1:0] proximity_threshold_select;
  logic evt_present, evt_prox, prox_start;
  logic [31:0] status_word;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // one wait state: pready rises in the second access cycle
  // a write lands only at the edge that samples pready_ff high
  assign access = psel && penable && pready_ff;
  assign wr_en = access && pwrite;
  assign rd_en = access && !pwrite;
  assign alias_sel = paddr[3:2];
  assign base = {paddr[7:4], 4'h0};
  // unaligned words and blocks past the event mask are refused
  assign mapped = (paddr[1:0] == 2'h0) && (base <= ISER_OFF_EVT_MASK);

  // store, clear, set or toggle the implemented bits
  // the implemented-bit mask keeps reserved bits reading zero
  function automatic logic [31:0] apply_alias(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [1:0] sel,
    input logic [31:0] impl
  );
    logic [31:0] res;
    res = old;
    unique case (sel)
      ISER_ALIAS_WR: res = wd;
      ISER_ALIAS_CLR: res = old & ~wd;
      ISER_ALIAS_SET: res = old | wd;
      ISER_ALIAS_INV: res = old ^ wd;
    endcase
    return res & impl;
  endfunction

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  // handler mode and proximity threshold live in the control word
  assign multi_handler_select = control_ff[ISER_MULTI_POS];
  assign proximity_threshold_select = control_ff[ISER_THRESH_LSB +: ISER_LVL_W];

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  // per-source key is group level above sublevel
  // a zero group level keeps a source out of the contest
  always_comb begin
    for (int i = 0; i < ISER_SRC_N; i++) begin
      key[i] = prio_ff[i / 4][(i % 4) * ISER_PRIO_STRIDE +: ISER_KEY_W];
      eligible[i] = flag_ff[i] && enable_ff[i] && (key[i][ISER_GRP_LSB +: ISER_LVL_W] != 3'h0);
    end
  end

  // scan in index order, so equal keys go to the lowest source
  iser_pick #(
    .N(ISER_SRC_N)
  ) u_pick (
    .eligible(eligible),
    .key(key),
    .found(found),
    .best_idx(best_idx),
    .best_key(best_key)
  );

  // ----------------------------------------------------------------
  // presentation, proximity timer and events
  // ----------------------------------------------------------------
  always_comb begin
    // nothing eligible shows as level zero, index zero
    nxt_cpu_req.valid = found;
    nxt_cpu_req.level = found ? best_key[ISER_GRP_LSB +: ISER_LVL_W] : 3'h0;
    nxt_cpu_req.index = found ? best_idx : 6'h00;
    // single-handler mode funnels every source into handler zero
    nxt_cpu_handler = multi_handler_select ? nxt_cpu_req.index : 6'h00;
    // a new presentation is a change of source, not of level
    evt_present = found && (!cpu_req_ff.valid || cpu_req_ff.index != best_idx);
    // latest presented level is held after the request goes away
    nxt_last_level = evt_present ? nxt_cpu_req.level : last_level_ff;
    prox_start = evt_present && (proximity_threshold_select != 3'h0) &&
                 (nxt_cpu_req.level <= proximity_threshold_select);
    // timer counts down once a cycle; a zero reload never expires
    evt_prox = 1'b0;
    nxt_prox_cnt = prox_cnt_ff;
    if (prox_start) begin
      nxt_prox_cnt = reload_ff;
    end else if (proximity_threshold_select == 3'h0) begin
      nxt_prox_cnt = ISER_ZERO;
    end else if (prox_cnt_ff != ISER_ZERO) begin
      nxt_prox_cnt = prox_cnt_ff - 32'h0000_0001;
      evt_prox = (prox_cnt_ff == 32'h0000_0001);
    end
    nxt_prox_expired = evt_prox;
  end

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  // bits 31:11 and 7:6 stay zero
  always_comb begin
    status_word = ISER_ZERO;
    // level from the held copy, index from the live request
    status_word[ISER_LEVEL_LSB +: ISER_LVL_W] = last_level_ff;
    // index is meaningful to software only in single-handler mode
    status_word[ISER_INDEX_LSB +: ISER_IDX_W] = cpu_req_ff.index;
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_comb begin
    nxt_control = control_ff;
    nxt_reload = reload_ff;
    nxt_flag = flag_ff;
    nxt_enable = enable_ff;
    nxt_prio = prio_ff;
    nxt_evt_stat = evt_stat_ff;
    nxt_evt_mask = evt_mask_ff;
    // status is read only: its base falls to the default arm and is dropped
    if (wr_en && mapped) begin
      unique case (base)
        ISER_OFF_CONTROL: nxt_control = apply_alias(control_ff, pwdata, alias_sel, ISER_CONTROL_MASK);
        ISER_OFF_RELOAD: nxt_reload = apply_alias(reload_ff, pwdata, alias_sel, 32'hFFFF_FFFF);
        ISER_OFF_FLAG: nxt_flag = apply_alias(flag_ff, pwdata, alias_sel, 32'hFFFF_FFFF);
        ISER_OFF_ENABLE: nxt_enable = apply_alias(enable_ff, pwdata, alias_sel, 32'hFFFF_FFFF);
        // event status clears by writing ones at its base only
        ISER_OFF_EVT_STAT: begin
          if (alias_sel == ISER_ALIAS_WR) begin
            nxt_evt_stat = evt_stat_ff & ~pwdata;
          end
        end
        ISER_OFF_EVT_MASK: nxt_evt_mask = apply_alias(evt_mask_ff, pwdata, alias_sel, ISER_EVT_MASK_BITS);
        default: begin
          // eight priority words, one block each
          if (base >= ISER_OFF_PRIO0 && base <= ISER_OFF_PRIO7) begin
            nxt_prio[3'(base[7:4] - 4'h5)] =
              apply_alias(prio_ff[3'(base[7:4] - 4'h5)], pwdata, alias_sel, ISER_PRIO_MASK);
          end
        end
      endcase
    end
    // a request arriving during a software clear is kept
    nxt_flag = nxt_flag | src_req;
    nxt_evt_stat[ISER_EVT_PRESENT] = nxt_evt_stat[ISER_EVT_PRESENT] | evt_present;
    nxt_evt_stat[ISER_EVT_PROX] = nxt_evt_stat[ISER_EVT_PROX] | evt_prox;
    // interrupt follows the event bits as they stand after this edge
    nxt_irq = |(nxt_evt_stat & evt_mask_ff);
  end

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  always_comb begin
    // answer only in the first access cycle, so it is a one-cycle pulse
    nxt_pready = psel && penable && !pready_ff;
    nxt_pslverr = nxt_pready && !mapped;
    // read data stay zero outside the answer, so no stale word shows
    nxt_prdata = ISER_ZERO;
    if (nxt_pready && !pwrite && mapped) begin
      unique case (base)
        ISER_OFF_CONTROL: nxt_prdata = control_ff;
        ISER_OFF_STATUS: nxt_prdata = status_word;
        ISER_OFF_RELOAD: nxt_prdata = reload_ff;
        ISER_OFF_FLAG: nxt_prdata = flag_ff;
        ISER_OFF_ENABLE: nxt_prdata = enable_ff;
        ISER_OFF_EVT_STAT: nxt_prdata = evt_stat_ff;
        ISER_OFF_EVT_MASK: nxt_prdata = evt_mask_ff;
        default: begin
          if (base >= ISER_OFF_PRIO0 && base <= ISER_OFF_PRIO7) begin
            nxt_prdata = prio_ff[3'(base[7:4] - 4'h5)];
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // configuration written by software, cleared on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_ff <= ISER_RST_WORD;
      reload_ff <= ISER_RST_WORD;
      enable_ff <= ISER_RST_WORD;
      prio_ff <= '0;
      evt_mask_ff <= ISER_RST_WORD;
    end else begin
      control_ff <= nxt_control;
      reload_ff <= nxt_reload;
      enable_ff <= nxt_enable;
      prio_ff <= nxt_prio;
      evt_mask_ff <= nxt_evt_mask;
    end
  end

  // sticky flags, event status and the interrupt line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_ff <= ISER_RST_WORD;
      evt_stat_ff <= ISER_RST_WORD;
      irq_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
      evt_stat_ff <= nxt_evt_stat;
      irq_ff <= nxt_irq;
    end
  end

  // presentation to the cpu and proximity timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prox_cnt_ff <= ISER_RST_WORD;
      last_level_ff <= 3'h0;
      cpu_req_ff <= '0;
      cpu_handler_ff <= 6'h00;
      prox_expired_ff <= 1'b0;
    end else begin
      prox_cnt_ff <= nxt_prox_cnt;
      last_level_ff <= nxt_last_level;
      cpu_req_ff <= nxt_cpu_req;
      cpu_handler_ff <= nxt_cpu_handler;
      prox_expired_ff <= nxt_prox_expired;
    end
  end

  // bus answer, one cycle wide
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= ISER_RST_WORD;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

endmodule

/* core/iser_pkg.sv */
package iser_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int ISER_SRC_N = 32;
  localparam int ISER_IDX_W = 6;
  localparam int ISER_LVL_W = 3;
  localparam int ISER_SUB_W = 2;
  localparam int ISER_KEY_W = 5;
  localparam int ISER_ADDR_W = 8;
  localparam int ISER_PRIO_WORDS = 8;

  // ----------------------------------------------------------------
  // register offsets (each base owns base+0x0 .. base+0xC)
  // ----------------------------------------------------------------
  localparam logic [7:0] ISER_OFF_CONTROL = 8'h00;
  localparam logic [7:0] ISER_OFF_STATUS = 8'h10;
  localparam logic [7:0] ISER_OFF_RELOAD = 8'h20;
  localparam logic [7:0] ISER_OFF_FLAG = 8'h30;
  localparam logic [7:0] ISER_OFF_ENABLE = 8'h40;
  localparam logic [7:0] ISER_OFF_PRIO0 = 8'h50;
  localparam logic [7:0] ISER_OFF_PRIO7 = 8'hC0;
  localparam logic [7:0] ISER_OFF_EVT_STAT = 8'hD0;
  localparam logic [7:0] ISER_OFF_EVT_MASK = 8'hE0;

  // alias selected by address bits 3:2
  localparam logic [1:0] ISER_ALIAS_WR = 2'h0;
  localparam logic [1:0] ISER_ALIAS_CLR = 2'h1;
  localparam logic [1:0] ISER_ALIAS_SET = 2'h2;
  localparam logic [1:0] ISER_ALIAS_INV = 2'h3;

  // ----------------------------------------------------------------
  // field positions and implemented-bit masks
  // ----------------------------------------------------------------
  localparam int ISER_MULTI_POS = 12;
  localparam int ISER_THRESH_LSB = 8;
  localparam int ISER_LEVEL_LSB = 8;
  localparam int ISER_INDEX_LSB = 0;
  localparam int ISER_PRIO_STRIDE = 8;
  localparam int ISER_SUB_LSB = 0;
  localparam int ISER_GRP_LSB = 2;
  localparam int ISER_EVT_PRESENT = 0;
  localparam int ISER_EVT_PROX = 1;
  localparam logic [31:0] ISER_CONTROL_MASK = 32'h0000_1700;
  localparam logic [31:0] ISER_PRIO_MASK = 32'h1F1F_1F1F;
  localparam logic [31:0] ISER_EVT_MASK_BITS = 32'h0000_0003;
  localparam logic [31:0] ISER_ZERO = 32'h0000_0000;

  // reset values
  localparam logic [31:0] ISER_RST_WORD = 32'h0000_0000;

  // request presented to the cpu
  typedef struct packed {
    logic valid;
    logic [ISER_LVL_W-1:0] level;
    logic [ISER_IDX_W-1:0] index;
  } iser_cpu_req_t;

endpackage

/* core/iser_pick.sv */
`timescale 1ns/1ps
module iser_pick
  import iser_pkg::*;
#(
  parameter int N = ISER_SRC_N
) (
  input wire logic [N-1:0] eligible,
  input wire logic [N-1:0][ISER_KEY_W-1:0] key,
  output logic found,
  output logic [ISER_IDX_W-1:0] best_idx,
  output logic [ISER_KEY_W-1:0] best_key
);

  // ----------------------------------------------------------------
  // highest key wins, lowest index breaks a tie
  // ----------------------------------------------------------------
  always_comb begin
    found = 1'b0;
    best_idx = '0;
    best_key = '0;
    for (int i = 0; i < N; i++) begin
      if (eligible[i] && (!found || key[i] > best_key)) begin
        found = 1'b1;
        best_idx = ISER_IDX_W'(i);
        best_key = key[i];
      end
    end
  end

endmodule

/* bench/iser_top_sva.sv */
`timescale 1ns/1ps
// --------------------------------
// bus and cpu-side checks
// --------------------------------
module iser_chk
  import iser_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ISER_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata_ff,
  input wire logic pready_ff,
  input wire logic pslverr_ff,
  input wire logic [ISER_SRC_N-1:0] src_req,
  input wire iser_cpu_req_t cpu_req_ff,
  input wire logic [ISER_IDX_W-1:0] cpu_handler_ff,
  input wire logic prox_expired_ff,
  input wire logic irq_ff
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // answer is a single pulse, one cycle after the first access cycle
  a_ready_one_cycle: assert property (pready_ff |=> !pready_ff) else $error("ready held too long");
  a_ready_timing: assert property (psel && penable && !pready_ff && !$past(penable) |=> pready_ff)
    else $error("ready late");
  a_err_with_ready: assert property (pslverr_ff |-> pready_ff) else $error("error without ready");
  a_err_unaligned: assert property (psel && penable && pready_ff && paddr[1:0] != 2'h0 |-> pslverr_ff)
    else $error("unaligned not refused");
  a_no_err_mapped: assert property (psel && penable && pready_ff && paddr[1:0] == 2'h0 && paddr < 8'hF0
    |-> !pslverr_ff) else $error("mapped access refused");
  a_rdata_idle: assert property (!pready_ff |-> prdata_ff == ISER_ZERO) else $error("read data outside answer");
  a_status_unimpl: assert property (pready_ff && !pwrite && paddr[7:4] == 4'h1 |-> (prdata_ff & 32'hFFFF_F8C0) == ISER_ZERO)
    else $error("status reserved bits set");
  a_level_nonzero: assert property (cpu_req_ff.valid |-> cpu_req_ff.level != 3'h0) else $error("level zero presented");
  a_index_range: assert property (cpu_req_ff.valid |-> cpu_req_ff.index < 6'h20) else $error("index out of range");
  a_prox_pulse: assert property (prox_expired_ff |=> !prox_expired_ff) else $error("expiry not a pulse");
endmodule

bind iser_top iser_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
  .src_req(src_req), .cpu_req_ff(cpu_req_ff), .cpu_handler_ff(cpu_handler_ff),
  .prox_expired_ff(prox_expired_ff), .irq_ff(irq_ff));

/* bench/iser_cpu_model.sv */
`timescale 1ns/1ps
module iser_cpu_model
  import iser_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic multi_sel,
  input wire iser_cpu_req_t cpu_req,
  input wire logic [ISER_IDX_W-1:0] handler,
  output logic [ISER_IDX_W-1:0] taken_idx_ff
);
  iser_cpu_req_t last_ff;
  // core vectors on each new presentation; status index trusted only in single mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_ff <= '0;
      taken_idx_ff <= '0;
    end else begin
      last_ff <= cpu_req;
      if (cpu_req.valid && cpu_req != last_ff) begin
        taken_idx_ff <= multi_sel ? handler : cpu_req.index;
      end
    end
  end
endmodule

/* bench/iser_top_tb_top.sv */
`timescale 1ns/1ps
module iser_top_tb_top
  import iser_pkg::*;
;
  typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex; logic er;} iser_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready_ff, pslverr_ff, prox_expired_ff, irq_ff, multi_sel;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata_ff, src_req, v;
  logic e;
  iser_cpu_req_t cpu_req_ff;
  logic [5:0] cpu_handler_ff, taken;
  int err_count, n_tests, k;
  iser_row_t rows [10] = '{
    '{8'h20, 32'hFFFF_FFFF, 8'h20, 32'hFFFF_FFFF, 1'b0}, '{8'h30, 32'hA5A5_A5A5, 8'h30, 32'hA5A5_A5A5, 1'b0},
    '{8'h40, 32'h5A5A_5A5A, 8'h40, 32'h5A5A_5A5A, 1'b0}, '{8'h44, 32'h0000_000F, 8'h40, 32'h5A5A_5A50, 1'b0},
    '{8'h48, 32'h0000_000F, 8'h40, 32'h5A5A_5A5F, 1'b0}, '{8'h4C, 32'hFFFF_0000, 8'h40, 32'hA5A5_5A5F, 1'b0},
    '{8'h00, 32'hFFFF_FFFF, 8'h00, 32'h0000_1700, 1'b0}, '{8'h10, 32'hFFFF_FFFF, 8'h10, 32'h0000_0000, 1'b0},
    '{8'hF0, 32'h0000_0001, 8'hF0, 32'h0000_0000, 1'b1}, '{8'h31, 32'h0000_0001, 8'h31, 32'h0000_0000, 1'b1}};

  iser_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .src_req(src_req),
    .cpu_req_ff(cpu_req_ff), .cpu_handler_ff(cpu_handler_ff), .prox_expired_ff(prox_expired_ff), .irq_ff(irq_ff));
  iser_cpu_model cpu_u (.pclk(pclk), .presetn(presetn), .multi_sel(multi_sel), .cpu_req(cpu_req_ff),
    .handler(cpu_handler_ff), .taken_idx_ff(taken));

  // ------------------------------
  // clock, helpers
  // ------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready_ff !== 1'b1);
    v = prdata_ff;
    e = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic pulse(input int b);
    src_req <= 32'h0000_0001 << b;
    @(posedge pclk);
    src_req <= 32'h0000_0000;
    repeat (3) @(posedge pclk);
  endtask

  task automatic complete_run();
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    complete_run();
  end

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    {presetn, psel, penable, pwrite, multi_sel} = 5'h00;
    {paddr, pwdata, src_req} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].wa, rows[i].wd);
      apb(1'b0, rows[i].ra, 32'h0);
      chk(v, rows[i].ex);
      chk({31'h0, e}, {31'h0, rows[i].er});
    end
    $display("register rows done");
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (k = 0; k < 15; k++) begin
      apb(1'b0, 8'(k * 16), 32'h0);
      chk(v, ISER_RST_WORD);
    end
    $display("reset values done");
    apb(1'b1, 8'h40, 32'h0000_0028);
    apb(1'b1, 8'h50, 32'h0800_0000);
    apb(1'b1, 8'h60, 32'h0000_1500);
    apb(1'b1, 8'h20, 32'h0000_0010);
    apb(1'b1, 8'h00, 32'h0000_0700);
    apb(1'b1, 8'hE0, 32'h0000_0001);
    pulse(3);
    chk({22'h0, cpu_req_ff}, 32'h0000_0283);
    chk({26'h0, taken}, 32'h0000_0003);
    chk({31'h0, irq_ff}, 32'h0000_0001);
    k = 0;
    while (prox_expired_ff !== 1'b1 && k < 40) begin
      @(posedge pclk);
      k++;
    end
    chk({31'h0, prox_expired_ff}, 32'h0000_0001);
    apb(1'b0, 8'h10, 32'h0);
    chk(v, 32'h0000_0203);
    pulse(5);
    chk({22'h0, cpu_req_ff}, 32'h0000_0345);
    apb(1'b0, 8'h10, 32'h0);
    chk(v, 32'h0000_0505);
    $display("presentation done");
    apb(1'b1, 8'hE0, 32'h0000_0000);
    @(posedge pclk);
    chk({31'h0, irq_ff}, 32'h0000_0000);
    apb(1'b1, 8'hE0, 32'h0000_0001);
    @(posedge pclk);
    chk({31'h0, irq_ff}, 32'h0000_0001);
    apb(1'b1, 8'hD0, 32'h0000_0003);
    chk({31'h0, irq_ff}, 32'h0000_0000);
    $display("interrupt done");
    multi_sel <= 1'b1;
    apb(1'b1, 8'h00, 32'h0000_1700);
    @(posedge pclk);
    chk({26'h0, cpu_handler_ff}, 32'h0000_0005);
    apb(1'b1, 8'h34, 32'h0000_0020);
    repeat (2) @(posedge pclk);
    chk({26'h0, cpu_handler_ff}, 32'h0000_0003);
    chk({26'h0, taken}, 32'h0000_0003);
    apb(1'b1, 8'h34, 32'h0000_0008);
    apb(1'b0, 8'h10, 32'h0);
    chk(v, 32'h0000_0200);
    $display("vectoring done");
    complete_run();
  end
endmodule
